// ### rtl/edge_trim_pkg.sv
// Shared constants for the PWM edge trim register block.
package edge_trim_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_TRIM_C = 10'h06b;
    localparam logic [9:0] IDX_TRIM_D = 10'h06c;
    localparam logic [9:0] IDX_STATUS = 10'h070;

    localparam logic [11:0] ADDR_TRIM_C = {IDX_TRIM_C, 2'b00};
    localparam logic [11:0] ADDR_TRIM_D = {IDX_TRIM_D, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // Field positions inside a trim register.
    localparam int POL_HI_BIT = 7;
    localparam int OFS_HI_MSB = 6;
    localparam int OFS_HI_LSB = 4;
    localparam int POL_LO_BIT = 3;
    localparam int OFS_LO_MSB = 2;
    localparam int OFS_LO_LSB = 0;

    // Field positions inside the status register.
    localparam int STAT_PEND_BIT  = 0;
    localparam int STAT_ACT_C_LSB = 8;
    localparam int STAT_ACT_D_LSB = 16;

    // Reset values.
    localparam logic [7:0] TRIM_RST = 8'h00;

    // Trim step, system clock timing and offset field widths.
    localparam int STEP_NS       = 5;
    localparam int CLK_PERIOD_NS = 40;
    localparam int OFS_CODE_W    = 3;
    localparam int OFS_NS_W      = 6;

endpackage : edge_trim_pkg

// ### rtl/edge_trim_unit.sv
// One trimmed PWM edge: holds the active polarity and offset of one edge.
module edge_trim_unit #(
    parameter int CODE_W  = edge_trim_pkg::OFS_CODE_W,
    parameter int NS_W    = edge_trim_pkg::OFS_NS_W,
    parameter int STEP_NS = edge_trim_pkg::STEP_NS
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Staged setting and the boundary strobe that applies it.
    input  wire logic              pol_i,
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic              load_i,
    // Active setting seen by the PWM generator.
    output logic                   pol_o,
    output logic [CODE_W-1:0]      code_o,
    output logic [NS_W-1:0]        ns_o
);

    logic              pol_q;
    logic [CODE_W-1:0] code_q;
    logic [NS_W-1:0]   ns_q;
    logic [NS_W-1:0]   ns_d;

    // The offset grows linearly by one step per code value.
    assign ns_d = NS_W'(code_i * STEP_NS);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pol_q  <= 1'b0;
            code_q <= '0;
            ns_q   <= '0;
        end else if (load_i) begin
            pol_q  <= pol_i;
            code_q <= code_i;
            ns_q   <= ns_d;
        end
    end

    assign pol_o  = pol_q;
    assign code_o = code_q;
    assign ns_o   = ns_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_unit_load_takes: assert property (
        load_i |=> (pol_q == $past(pol_i)) && (code_q == $past(code_i)))
        else $error("Edge setting not taken on load.");
    chk_unit_holds: assert property (
        !load_i |=> $stable(pol_q) && $stable(code_q) && $stable(ns_q))
        else $error("Edge setting changed without a load.");
    chk_unit_ns_scale: assert property (
        ns_q == NS_W'(code_q * STEP_NS))
        else $error("Edge offset in ns does not match its code.");

endmodule : edge_trim_unit

// ### rtl/edge_trim_regs.sv
// APB register block that trims PWM edges five to eight.

module edge_trim_regs #(
    parameter int ADDR_W  = 12,
    parameter int EDGES   = 4,
    parameter int CODE_W  = edge_trim_pkg::OFS_CODE_W,
    parameter int NS_W    = edge_trim_pkg::OFS_NS_W
) (
    // Clock and reset.
    input  wire logic                   CLK_SYS_I,
    input  wire logic                   RST_N_I,
    // APB slave.
    input  wire logic                   PSEL_I,
    input  wire logic                   PENABLE_I,
    input  wire logic                   PWRITE_I,
    input  wire logic [ADDR_W-1:0]      PADDR_I,
    input  wire logic [31:0]            PWDATA_I,
    input  wire logic [3:0]             PSTRB_I,
    output logic [31:0]                 PRDATA_O,
    output logic                        PREADY_O,
    output logic                        PSLVERR_O,
    // PWM generator side.
    input  wire logic                   PERIOD_START_I,
    output logic [EDGES-1:0]            EDGE_POL_O,
    output logic [EDGES*CODE_W-1:0]     EDGE_CODE_O,
    output logic [EDGES*NS_W-1:0]       EDGE_OFFSET_NS_O,
    output logic                        UPDATE_PENDING_O
);

    // Staged register contents as written by software, then the pending flag and the bus response registers.
    logic [7:0]  trim_c_q;
    logic [7:0]  trim_c_d;
    logic [7:0]  trim_d_q;
    logic [7:0]  trim_d_d;
    logic        pending_q;
    logic        pending_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        slverr_q;
    logic        slverr_d;

    // Bus decode.
    wire         setup_ph  = PSEL_I && !PENABLE_I;
    wire         access_ph = PSEL_I && PENABLE_I;
    wire         hit_c     = (PADDR_I == edge_trim_pkg::ADDR_TRIM_C);
    wire         hit_d     = (PADDR_I == edge_trim_pkg::ADDR_TRIM_D);
    wire         hit_stat  = (PADDR_I == edge_trim_pkg::ADDR_STATUS);
    wire         mapped    = hit_c || hit_d || hit_stat;
    wire         lane0     = PSTRB_I[0];
    wire         wr_c      = access_ph && PWRITE_I && hit_c && lane0;
    wire         wr_d      = access_ph && PWRITE_I && hit_d && lane0;
    wire         wr_any    = wr_c || wr_d;
    wire         bad_acc   = !mapped || (PWRITE_I && hit_stat);

    // Active settings rebuilt for read-back.
    wire [7:0]   act_c;
    wire [7:0]   act_d;

    // Staged edge settings split into fields.
    wire [EDGES-1:0]        stg_pol;
    wire [EDGES*CODE_W-1:0] stg_code;

    assign stg_pol[0] = trim_c_q[edge_trim_pkg::POL_HI_BIT];
    assign stg_pol[1] = trim_c_q[edge_trim_pkg::POL_LO_BIT];
    assign stg_pol[2] = trim_d_q[edge_trim_pkg::POL_HI_BIT];
    assign stg_pol[3] = trim_d_q[edge_trim_pkg::POL_LO_BIT];

    // Edge five offset code.
    assign stg_code[0*CODE_W +: CODE_W] =
        trim_c_q[edge_trim_pkg::OFS_HI_MSB:edge_trim_pkg::OFS_HI_LSB];
    // Edge six offset code.
    assign stg_code[1*CODE_W +: CODE_W] =
        trim_c_q[edge_trim_pkg::OFS_LO_MSB:edge_trim_pkg::OFS_LO_LSB];
    // Edge seven offset code.
    assign stg_code[2*CODE_W +: CODE_W] =
        trim_d_q[edge_trim_pkg::OFS_HI_MSB:edge_trim_pkg::OFS_HI_LSB];
    // Edge eight offset code.
    assign stg_code[3*CODE_W +: CODE_W] =
        trim_d_q[edge_trim_pkg::OFS_LO_MSB:edge_trim_pkg::OFS_LO_LSB];

    // Register writes.
    assign trim_c_d = wr_c ? PWDATA_I[7:0] : trim_c_q;
    assign trim_d_d = wr_d ? PWDATA_I[7:0] : trim_d_q;

    // A write that meets a boundary keeps the pending flag set.
    assign pending_d = wr_any || (pending_q && !PERIOD_START_I);

    // Read data is captured in the setup phase and held for the access.
    assign rdata_d =
        !setup_ph          ? rdata_q :
        PWRITE_I           ? 32'h0000_0000 :
        hit_c              ? {24'h00_0000, trim_c_q} :
        hit_d              ? {24'h00_0000, trim_d_q} :
        hit_stat           ? {8'h00, act_d, act_c, 7'h00, pending_q} :
                             32'h0000_0000;
    assign slverr_d = setup_ph ? bad_acc : slverr_q;

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            trim_c_q  <= edge_trim_pkg::TRIM_RST;
            trim_d_q  <= edge_trim_pkg::TRIM_RST;
            pending_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            slverr_q  <= 1'b0;
        end else begin
            trim_c_q  <= trim_c_d;
            trim_d_q  <= trim_d_d;
            pending_q <= pending_d;
            rdata_q   <= rdata_d;
            slverr_q  <= slverr_d;
        end
    end

    // Settings pass to the edges only at a period boundary.
    wire apply = PERIOD_START_I;

    wire [EDGES-1:0]        act_pol;
    wire [EDGES*CODE_W-1:0] act_code;

    generate
        for (genvar e = 0; e < EDGES; e++) begin : g_edge
            edge_trim_unit #(
                .CODE_W  (CODE_W),
                .NS_W    (NS_W),
                .STEP_NS (edge_trim_pkg::STEP_NS)
            ) u_edge (
                .clk_i   (CLK_SYS_I),
                .rst_n_i (RST_N_I),
                .pol_i   (stg_pol[e]),
                .code_i  (stg_code[e*CODE_W +: CODE_W]),
                .load_i  (apply),
                .pol_o   (act_pol[e]),
                .code_o  (act_code[e*CODE_W +: CODE_W]),
                .ns_o    (EDGE_OFFSET_NS_O[e*NS_W +: NS_W])
            );
        end
    endgenerate

    assign act_c = {act_pol[0], act_code[0*CODE_W +: CODE_W],
                    act_pol[1], act_code[1*CODE_W +: CODE_W]};
    assign act_d = {act_pol[2], act_code[2*CODE_W +: CODE_W],
                    act_pol[3], act_code[3*CODE_W +: CODE_W]};

    // Outputs.
    assign PREADY_O         = 1'b1;
    assign PRDATA_O         = rdata_q;
    assign PSLVERR_O        = access_ph && slverr_q;
    assign EDGE_POL_O       = act_pol;
    assign EDGE_CODE_O      = act_code;
    assign UPDATE_PENDING_O = pending_q;

    // Checks.
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_write_c;
        wr_c;
    endsequence

    sequence s_write_d;
        wr_d;
    endsequence

    sequence s_boundary;
        PERIOD_START_I;
    endsequence

    sequence s_read_d;
        setup_ph && !PWRITE_I && hit_d ##1 access_ph;
    endsequence

    sequence s_read_stat;
        setup_ph && !PWRITE_I && hit_stat ##1 access_ph;
    endsequence

    chk_trim_c_write: assert property (
        s_write_c |=> trim_c_q == $past(PWDATA_I[7:0]))
        else $error("Write to first trim register not stored.");

    chk_trim_d_write: assert property (
        s_write_d |=> trim_d_q == $past(PWDATA_I[7:0]))
        else $error("Write to second trim register not stored.");

    chk_edge_five_ofs: assert property (
        s_boundary |=>
            EDGE_CODE_O[2:0] == $past(trim_c_q[6:4]) &&
            EDGE_OFFSET_NS_O[5:0] ==
                NS_W'($past(trim_c_q[6:4]) * 5))
        else $error("Edge five offset not applied from bits 6:4.");

    chk_edge_six_ofs: assert property (
        s_boundary |=>
            EDGE_CODE_O[5:3] == $past(trim_c_q[2:0]) &&
            EDGE_OFFSET_NS_O[11:6] ==
                NS_W'($past(trim_c_q[2:0]) * 5))
        else $error("Edge six offset not applied from bits 2:0.");

    chk_edge_seven_ofs: assert property (
        s_boundary |=>
            EDGE_CODE_O[8:6] == $past(trim_d_q[6:4]) &&
            EDGE_OFFSET_NS_O[17:12] ==
                NS_W'($past(trim_d_q[6:4]) * 5))
        else $error("Edge seven offset not applied from bits 6:4.");

    chk_edge_eight_ofs: assert property (
        s_boundary |=>
            EDGE_CODE_O[11:9] == $past(trim_d_q[2:0]) &&
            EDGE_OFFSET_NS_O[23:18] ==
                NS_W'($past(trim_d_q[2:0]) * 5))
        else $error("Edge eight offset not applied from bits 2:0.");

    chk_polarity_map: assert property (
        s_boundary |=>
            EDGE_POL_O == {$past(trim_d_q[3]), $past(trim_d_q[7]),
                           $past(trim_c_q[3]), $past(trim_c_q[7])})
        else $error("Edge polarity bits not mapped from bits 7 and 3.");

    chk_no_mid_period: assert property (
        !PERIOD_START_I |=> $stable(EDGE_POL_O) && $stable(EDGE_CODE_O))
        else $error("Edge setting changed inside a period.");

    chk_pending_set: assert property (
        wr_any |=> pending_q [*1] ##0
            (PERIOD_START_I [*1] or !PERIOD_START_I) ##1
            (pending_q || (!$past(wr_any) && $past(PERIOD_START_I))))
        else $error("Pending flag lost after a write.");

    chk_pending_clear: assert property (
        PERIOD_START_I && !wr_any |=> !pending_q)
        else $error("Pending flag not cleared at the boundary.");

    chk_read_back_c: assert property (
        setup_ph && !PWRITE_I && hit_c ##1 access_ph |->
            PRDATA_O == {24'h00_0000, $past(trim_c_q)})
        else $error("First trim register read returns wrong data.");

    chk_unmapped_err: assert property (
        setup_ph && !mapped ##1 access_ph |-> PSLVERR_O)
        else $error("Unmapped access not flagged as an error.");

    chk_read_back_d: assert property (
        s_read_d |-> PRDATA_O == {24'h00_0000, $past(trim_d_q)})
        else $error("Second trim register read returns wrong data.");

    chk_status_read: assert property (
        s_read_stat |-> PRDATA_O ==
            {8'h00, $past(act_d), $past(act_c), 7'h00, $past(pending_q)})
        else $error("Status read does not show the active settings.");

    chk_trim_c_ok: assert property (
        setup_ph && hit_c ##1 access_ph |-> !PSLVERR_O)
        else $error("Access to first trim register flagged as an error.");

    chk_trim_d_ok: assert property (
        setup_ph && hit_d ##1 access_ph |-> !PSLVERR_O)
        else $error("Access to second trim register flagged as an error.");

    chk_stat_rd_ok: assert property (
        s_read_stat |-> !PSLVERR_O)
        else $error("Status read flagged as an error.");

    chk_stat_wr_err: assert property (
        setup_ph && PWRITE_I && hit_stat ##1 access_ph |-> PSLVERR_O)
        else $error("Status write not flagged as an error.");

    chk_bad_no_effect: assert property (
        setup_ph && bad_acc ##1 access_ph |=>
            $stable(trim_c_q) && $stable(trim_d_q))
        else $error("Refused access changed a trim register.");

    chk_keep_c: assert property (
        !wr_c |=> $stable(trim_c_q))
        else $error("First trim register changed without a write.");

    chk_keep_d: assert property (
        !wr_d |=> $stable(trim_d_q))
        else $error("Second trim register changed without a write.");

    chk_apply_c: assert property (
        s_boundary |=> act_c == $past(trim_c_q))
        else $error("First register image not applied at the boundary.");

    chk_apply_d: assert property (
        s_boundary |=> act_d == $past(trim_d_q))
        else $error("Second register image not applied at the boundary.");

    chk_pending_write: assert property (
        wr_any |=> pending_q)
        else $error("Pending flag not set after a write.");

    chk_write_wins: assert property (
        wr_any && PERIOD_START_I |=> pending_q)
        else $error("Write at a boundary did not stay pending.");

    chk_pending_idle: assert property (
        !wr_any && !PERIOD_START_I |=> $stable(pending_q))
        else $error("Pending flag changed with no write or boundary.");

    chk_rdata_hold: assert property (
        !setup_ph |=> $stable(PRDATA_O))
        else $error("Read data changed outside a setup cycle.");

endmodule : edge_trim_regs

// ### tb/pwm_period_model.sv
// Partner model of the PWM generator that marks period boundaries.
module pwm_period_model #(
    parameter int PERIOD = 8
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Run control and boundary pulse.
    input  wire logic run_i,
    output logic      period_start_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int cnt_q;

    // Pulses stop at once when the bench halts the generator.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_i) begin
            cnt_q          <= 0;
            period_start_o <= 1'b0;
        end else begin
            cnt_q          <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            period_start_o <= (cnt_q == PERIOD - 1);
        end
    end
endmodule : pwm_period_model

// ### tb/testbench.sv
// Self-checking bench for the PWM edge trim register block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pstart;
    logic        run;
    logic [3:0]  pol;
    logic [11:0] code;
    logic [23:0] ns;
    logic        pend;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  c;
    logic [7:0]  d;
    logic [7:0]  pc;
    logic [7:0]  pd;
    int          checks;
    int          bad_count;
    int          n;

    edge_trim_regs uut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PERIOD_START_I(pstart),
        .EDGE_POL_O(pol), .EDGE_CODE_O(code), .EDGE_OFFSET_NS_O(ns),
        .UPDATE_PENDING_O(pend)
    );

    pwm_period_model partner (
        .clk_i(clk), .rst_n_i(rst_n), .run_i(run), .period_start_o(pstart)
    );

    always #20 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Expected code and offset in ns of one edge, code above ns.
    function automatic logic [31:0] exp_edge(input logic [2:0] x);
        return {23'h0, x, 6'(x * edge_trim_pkg::STEP_NS)};
    endfunction : exp_edge

    // Active edge outputs against the two bytes last applied.
    task automatic out_chk(input logic [7:0] ec, input logic [7:0] ed);
        check({28'h0, pol}, {28'h0, ed[3], ed[7], ec[3], ec[7]});
        check({23'h0, code[2:0], ns[5:0]}, exp_edge(ec[6:4]));
        check({23'h0, code[5:3], ns[11:6]}, exp_edge(ec[2:0]));
        check({23'h0, code[8:6], ns[17:12]}, exp_edge(ed[6:4]));
        check({23'h0, code[11:9], ns[23:18]}, exp_edge(ed[2:0]));
    endtask : out_chk

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] dat, input logic [3:0] s);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dat;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        check(rd, exp);
        check({31'h0, err}, 32'h0);
    endtask : rd_chk

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, run} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        checks = 0;
        bad_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(edge_trim_pkg::ADDR_TRIM_C, 32'h0);
        rd_chk(edge_trim_pkg::ADDR_TRIM_D, 32'h0);
        out_chk(8'h00, 8'h00);
        check({31'h0, pend}, 32'h0);
        pc = 8'h00;
        pd = 8'h00;
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            c = {k[0], 3'(k), ~k[0], 3'(7 - k)};
            d = {k[1], 3'(k + 3), k[2], 3'(k + 5)};
            apb(1'b1, edge_trim_pkg::ADDR_TRIM_C, {24'h0, c}, 4'hf);
            apb(1'b1, edge_trim_pkg::ADDR_TRIM_D, {24'h0, d}, 4'hf);
            rd_chk(edge_trim_pkg::ADDR_TRIM_C, {24'h0, c});
            rd_chk(edge_trim_pkg::ADDR_TRIM_D, {24'h0, d});
            check({31'h0, pend}, 32'h1);
            out_chk(pc, pd);
            run <= 1'b1;
            n = 0;
            while (pend !== 1'b0 && n < 40) begin
                @(posedge clk);
                n++;
            end
            if (pend !== 1'b0) begin
                bad_count++;
                tally_and_finish();
            end
            run <= 1'b0;
            out_chk(c, d);
            pc = c;
            pd = d;
        end
        rd_chk(edge_trim_pkg::ADDR_STATUS,
               {8'h00, d, c, 8'h00});
        $display("test trim table done");
        apb(1'b1, edge_trim_pkg::ADDR_TRIM_C, 32'hffff_ff5a, 4'hf);
        rd_chk(edge_trim_pkg::ADDR_TRIM_C, 32'h0000_005a);
        apb(1'b1, edge_trim_pkg::ADDR_TRIM_C, 32'h0000_00ff, 4'h0);
        rd_chk(edge_trim_pkg::ADDR_TRIM_C, 32'h0000_005a);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, edge_trim_pkg::ADDR_STATUS, 32'h1, 4'hf);
        check({31'h0, err}, 32'h1);
        rd_chk(edge_trim_pkg::ADDR_STATUS,
               {8'h00, d, c, 8'h01});
        $display("test refusals done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(edge_trim_pkg::ADDR_TRIM_C, 32'h0);
        rd_chk(edge_trim_pkg::ADDR_STATUS, 32'h0);
        out_chk(8'h00, 8'h00);
        $display("test reset again done");
        tally_and_finish();
    end
endmodule : testbench
